// [rtl/dtd_pkg.sv]
package dtd_pkg;

  // decoded instruction forms of the data-transfer group
  typedef enum logic [3:0] {
    FORM_NONE        = 4'h0,
    FORM_COPY_TO_RM  = 4'h1,
    FORM_COPY_TO_REG = 4'h2,
    FORM_COPY_IMMREG = 4'h3,
    FORM_COPY_MEMACC = 4'h4,
    FORM_COPY_ACCMEM = 4'h5,
    FORM_SEG_LOAD    = 4'h6,
    FORM_SEG_STORE   = 4'h7,
    FORM_SIGN_EXT    = 4'h8,
    FORM_ZERO_EXT    = 4'h9,
    FORM_PUSH_RM     = 4'hA,
    FORM_PUSH_SEGN   = 4'hB,
    FORM_PUSH_SEGW   = 4'hC,
    FORM_PUSH_IMM    = 4'hD,
    FORM_POP_RM      = 4'hE
  } dtd_form_t;

  // kind of data access the instruction makes
  typedef enum logic [1:0] {
    ACC_NONE  = 2'h0,
    ACC_READ  = 2'h1,
    ACC_WRITE = 2'h2,
    ACC_BOTH  = 2'h3
  } dtd_access_t;

  localparam int CNT_W = 8;

  // opcode patterns
  localparam logic [7:0] OP_ESCAPE     = 8'h0F;
  localparam logic [6:0] OP_COPY_TORM  = 7'h44;
  localparam logic [6:0] OP_COPY_TOREG = 7'h45;
  localparam logic [3:0] OP_COPY_IMMRG = 4'hB;
  localparam logic [6:0] OP_COPY_MEMAC = 7'h50;
  localparam logic [6:0] OP_COPY_ACCME = 7'h51;
  localparam logic [7:0] OP_SEG_LOAD   = 8'h8E;
  localparam logic [7:0] OP_SEG_STORE  = 8'h8C;
  localparam logic [6:0] OP_SIGN_EXT   = 7'h5F;
  localparam logic [6:0] OP_ZERO_EXT   = 7'h5B;
  localparam logic [7:0] OP_GROUP_FF   = 8'hFF;
  localparam logic [2:0] EXT_PUSH_RM   = 3'h6;
  localparam logic [7:0] OP_POP_RM     = 8'h8F;
  localparam logic [2:0] EXT_POP_RM    = 3'h0;
  localparam logic [2:0] PSN_HEAD      = 3'h0;
  localparam logic [2:0] PSN_TAIL      = 3'h6;
  localparam logic [1:0] PSW_HEAD      = 2'h2;
  localparam logic [2:0] PSW_TAIL      = 3'h0;
  localparam logic [5:0] OP_PUSH_IMM   = 6'h1A;
  localparam logic [2:0] SEG_COUNT     = 3'h6;

  // addressing byte encodings
  localparam logic [1:0] MOD_REG       = 2'h3;
  localparam logic [1:0] MOD_NODISP    = 2'h0;
  localparam logic [2:0] RM_SIB        = 3'h4;
  localparam logic [2:0] RM_PAIR_LAST  = 3'h3;
  localparam logic [2:0] SIB_NO_INDEX  = 3'h4;
  localparam logic [2:0] SIB_NO_BASE   = 3'h5;

  // base clock counts
  localparam logic [CNT_W-1:0] CLK_2  = 8'h02;
  localparam logic [CNT_W-1:0] CLK_3  = 8'h03;
  localparam logic [CNT_W-1:0] CLK_4  = 8'h04;
  localparam logic [CNT_W-1:0] CLK_5  = 8'h05;
  localparam logic [CNT_W-1:0] CLK_6  = 8'h06;
  localparam logic [CNT_W-1:0] CLK_7  = 8'h07;
  localparam logic [CNT_W-1:0] CLK_9  = 8'h09;
  localparam logic [CNT_W-1:0] CLK_22 = 8'h16;
  localparam logic [CNT_W-1:0] CLK_23 = 8'h17;

  // penalty clocks
  localparam logic [CNT_W-1:0] PEN_EVEN_ONE = 8'h02;
  localparam logic [CNT_W-1:0] PEN_EVEN_TWO = 8'h04;
  localparam logic [CNT_W-1:0] PEN_ODD_ONE  = 8'h04;
  localparam logic [CNT_W-1:0] PEN_ODD_TWO  = 8'h08;
  localparam logic [CNT_W-1:0] PEN_EA_PAIR  = 8'h01;

endpackage

// [rtl/dtd_modrm_if.sv]
// addressing byte and scale-index byte, split for the decoder
interface dtd_modrm_if;
  logic [7:0] modrmByte;
  logic [7:0] sibByte;
  logic       addr32;
  logic [1:0] formField;
  logic [2:0] regField;
  logic [2:0] rmField;
  logic       regOperand;
  logic       twoRegEa;

  modport split (input modrmByte, sibByte, addr32,
                 output formField, regField, rmField, regOperand, twoRegEa);
  modport user  (output modrmByte, sibByte, addr32,
                 input formField, regField, rmField, regOperand, twoRegEa);
endinterface

// [rtl/dtd_modrm_split.sv]
module dtd_modrm_split
  import dtd_pkg::*;
(
  dtd_modrm_if.split mrm
);

  logic indexUsed;
  logic baseUsed;

  // field split, most significant first
  assign mrm.formField  = mrm.modrmByte[7:6];
  assign mrm.regField   = mrm.modrmByte[5:3];
  assign mrm.rmField    = mrm.modrmByte[2:0];
  assign mrm.regOperand = (mrm.modrmByte[7:6] == MOD_REG);

  // scale-index byte: index 100 means none; no base with mod 00, base 101
  assign indexUsed = (mrm.sibByte[5:3] != SIB_NO_INDEX);
  assign baseUsed  = !((mrm.modrmByte[7:6] == MOD_NODISP) &&
                       (mrm.sibByte[2:0] == SIB_NO_BASE));

  // two general register components cost an extra clock
  always_comb begin
    if (mrm.regOperand) begin
      mrm.twoRegEa = 1'b0;
    end else if (mrm.addr32) begin
      mrm.twoRegEa = (mrm.modrmByte[2:0] == RM_SIB) && indexUsed &&
                     baseUsed;
    end else begin
      // 16-bit forms 000..011 pair a base with an index register
      mrm.twoRegEa = (mrm.modrmByte[2:0] <= RM_PAIR_LAST);
    end
  end

endmodule

// [rtl/dtd_decode_timing.sv]
// Notes on behaviour
// - misaligned 16-bit or even 32-bit operand: add 2, or 4 if both
// - odd-address 32-bit operand: add 4, or 8 if read and write
// - each wait state adds one clock for every data access
// - 1000100w plus addressing byte: copy to reg/mem, 2 clocks
// - 1000101w: copy into register, 2 from register, 4 from memory
// - 1011 w reg immediate: short immediate copy to register, 2 clocks
// - 1010000w full displacement: memory to accumulator, 4 clocks
// - 1010001w full displacement: accumulator to memory, 2 clocks
// - 10001110 segment load: 2/5 real mode, 22/23 protected
// - 10001100 segment store to reg/mem: 2 clocks both modes
// - escape then 1011111w sign-extending copy: 3 reg, 6 memory
// - escape then 1011011w zero-extending copy: 3 reg, 6 memory
// - 11111111 ext 110 stack store: 5/7 real, 7/9 protected
// - escape then 10 sss 000 wide segment stack store: 2 or 4
// - 011010s0 immediate stack store: 2 real, 4 protected
// - 10001111 ext 000 stack load: 5/7 real, 7/9 protected
// - of a count pair, smaller is register operand, larger memory
// - two register components in the address add one clock
// - counts assume prefetched, no waits, no hold, no exception
module dtd_decode_timing
  import dtd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             instrValid,
  input  wire logic [7:0]       opByte0,
  input  wire logic [7:0]       opByte1,
  input  wire logic [7:0]       opByte2,
  input  wire logic [7:0]       sibByte,
  input  wire logic             addrSize32,
  input  wire logic             opSize32,
  input  wire logic             protMode,
  input  wire logic             addrOdd,
  input  wire logic [3:0]       waitStates,
  output logic                  resultValid,
  output logic                  formKnown,
  output dtd_form_t             formCode,
  output logic                  fullWidth,
  output logic                  memOperand,
  output logic [CNT_W-1:0]      baseClocks,
  output logic [CNT_W-1:0]      penaltyClocks,
  output logic [CNT_W-1:0]      totalClocks
);

  dtd_modrm_if mrm ();

  dtd_modrm_split u_split (
    .mrm (mrm.split)
  );

  dtd_form_t        formNow;
  dtd_access_t      accessNow;
  logic             escaped;
  logic             usesModrm;
  logic             implicitMem;
  logic             memNow;
  logic             wideNow;
  logic [1:0]       sizeNow;
  logic [CNT_W-1:0] baseNow;
  logic [CNT_W-1:0] alignNow;
  logic [CNT_W-1:0] waitNow;
  logic [CNT_W-1:0] eaNow;

  logic             validReg, validNext;
  logic             knownReg, knownNext;
  dtd_form_t        formReg, formNext;
  logic             wideReg, wideNext;
  logic             memReg, memNext;
  logic [CNT_W-1:0] baseReg, baseNext;
  logic [CNT_W-1:0] penReg, penNext;
  logic [CNT_W-1:0] totalReg, totalNext;

  // pick one of a register/memory count pair
  function automatic logic [CNT_W-1:0] pickPair(
    input logic             mem,
    input logic [CNT_W-1:0] regCount,
    input logic [CNT_W-1:0] memCount
  );
    pickPair = mem ? memCount : regCount;
  endfunction

  // pick the count for the current mode
  function automatic logic [CNT_W-1:0] pickMode(
    input logic             prot,
    input logic [CNT_W-1:0] realCount,
    input logic [CNT_W-1:0] protCount
  );
    pickMode = prot ? protCount : realCount;
  endfunction

  // escape-prefixed forms carry the addressing byte one byte later
  assign escaped       = (opByte0 == OP_ESCAPE);
  assign mrm.modrmByte = escaped ? opByte2 : opByte1;
  assign mrm.sibByte   = sibByte;
  assign mrm.addr32    = addrSize32;

  // opcode recognition
  always_comb begin
    formNow     = FORM_NONE;
    usesModrm   = 1'b0;
    implicitMem = 1'b0;
    if (escaped) begin
      if (opByte1[7:1] == OP_SIGN_EXT) begin
        formNow   = FORM_SIGN_EXT;
        usesModrm = 1'b1;
      end else if (opByte1[7:1] == OP_ZERO_EXT) begin
        formNow   = FORM_ZERO_EXT;
        usesModrm = 1'b1;
      end else if ((opByte1[7:6] == PSW_HEAD) &&
                   (opByte1[2:0] == PSW_TAIL) &&
                   (opByte1[5:3] < SEG_COUNT)) begin
        formNow     = FORM_PUSH_SEGW;
        implicitMem = 1'b1;
      end
    end else if (opByte0[7:1] == OP_COPY_TORM) begin
      formNow   = FORM_COPY_TO_RM;
      usesModrm = 1'b1;
    end else if (opByte0[7:1] == OP_COPY_TOREG) begin
      formNow   = FORM_COPY_TO_REG;
      usesModrm = 1'b1;
    end else if (opByte0[7:4] == OP_COPY_IMMRG) begin
      formNow = FORM_COPY_IMMREG;
    end else if (opByte0[7:1] == OP_COPY_MEMAC) begin
      formNow     = FORM_COPY_MEMACC;
      implicitMem = 1'b1;
    end else if (opByte0[7:1] == OP_COPY_ACCME) begin
      formNow     = FORM_COPY_ACCMEM;
      implicitMem = 1'b1;
    end else if ((opByte0 == OP_SEG_LOAD) &&
                 (mrm.regField < SEG_COUNT)) begin
      formNow   = FORM_SEG_LOAD;
      usesModrm = 1'b1;
    end else if ((opByte0 == OP_SEG_STORE) &&
                 (mrm.regField < SEG_COUNT)) begin
      formNow   = FORM_SEG_STORE;
      usesModrm = 1'b1;
    end else if ((opByte0 == OP_GROUP_FF) &&
                 (mrm.regField == EXT_PUSH_RM)) begin
      formNow   = FORM_PUSH_RM;
      usesModrm = 1'b1;
    end else if ((opByte0 == OP_POP_RM) &&
                 (mrm.regField == EXT_POP_RM)) begin
      formNow   = FORM_POP_RM;
      usesModrm = 1'b1;
    end else if ((opByte0[7:5] == PSN_HEAD) &&
                 (opByte0[2:0] == PSN_TAIL)) begin
      formNow     = FORM_PUSH_SEGN;
      implicitMem = 1'b1;
    end else if ((opByte0[7:2] == OP_PUSH_IMM) && !opByte0[0]) begin
      formNow     = FORM_PUSH_IMM;
      implicitMem = 1'b1;
    end
  end

  assign memNow = usesModrm ? !mrm.regOperand : implicitMem;

  // size bit: clear is byte, set is full width
  always_comb begin
    case (formNow)
      FORM_COPY_TO_RM, FORM_COPY_TO_REG, FORM_COPY_MEMACC,
      FORM_COPY_ACCMEM, FORM_SIGN_EXT, FORM_ZERO_EXT:
        wideNow = escaped ? opByte1[0] : opByte0[0];
      FORM_COPY_IMMREG: wideNow = opByte0[3];
      default:          wideNow = (formNow != FORM_NONE);
    endcase
  end

  // operand size class: 0 byte, 1 word, 2 double word
  always_comb begin
    if (!wideNow) begin
      sizeNow = 2'h0;
    end else if ((formNow == FORM_SIGN_EXT) ||
                 (formNow == FORM_ZERO_EXT) ||
                 (formNow == FORM_SEG_LOAD) ||
                 (formNow == FORM_SEG_STORE)) begin
      sizeNow = 2'h1; // selector or extended source is one word
    end else begin
      sizeNow = opSize32 ? 2'h2 : 2'h1;
    end
  end

  // base counts; they assume no waits, hold or exception
  always_comb begin
    case (formNow)
      FORM_COPY_TO_RM:  baseNow = CLK_2;
      FORM_COPY_TO_REG: baseNow = pickPair(memNow, CLK_2, CLK_4);
      FORM_COPY_IMMREG: baseNow = CLK_2;
      FORM_COPY_MEMACC: baseNow = CLK_4;
      FORM_COPY_ACCMEM: baseNow = CLK_2;
      FORM_SEG_LOAD:    baseNow = protMode ?
                          pickPair(memNow, CLK_22, CLK_23) :
                          pickPair(memNow, CLK_2, CLK_5);
      FORM_SEG_STORE:   baseNow = CLK_2;
      FORM_SIGN_EXT,
      FORM_ZERO_EXT:    baseNow = pickPair(memNow, CLK_3, CLK_6);
      FORM_PUSH_RM,
      FORM_POP_RM:      baseNow = protMode ?
                          pickPair(memNow, CLK_7, CLK_9) :
                          pickPair(memNow, CLK_5, CLK_7);
      FORM_PUSH_SEGN,
      FORM_PUSH_SEGW,
      FORM_PUSH_IMM:    baseNow = pickMode(protMode, CLK_2, CLK_4);
      default:          baseNow = '0;
    endcase
  end

  // data accesses each form makes
  always_comb begin
    case (formNow)
      FORM_COPY_TO_RM, FORM_SEG_STORE:
        accessNow = memNow ? ACC_WRITE : ACC_NONE;
      FORM_COPY_TO_REG, FORM_SEG_LOAD, FORM_SIGN_EXT, FORM_ZERO_EXT:
        accessNow = memNow ? ACC_READ : ACC_NONE;
      FORM_COPY_MEMACC: accessNow = ACC_READ;
      FORM_COPY_ACCMEM, FORM_PUSH_SEGN, FORM_PUSH_SEGW, FORM_PUSH_IMM:
        accessNow = ACC_WRITE;
      FORM_PUSH_RM:     accessNow = memNow ? ACC_BOTH : ACC_WRITE;
      FORM_POP_RM:      accessNow = memNow ? ACC_BOTH : ACC_READ;
      default:          accessNow = ACC_NONE;
    endcase
  end

  // alignment penalty; odd double word costs twice the even case
  always_comb begin
    alignNow = '0;
    if (accessNow != ACC_NONE) begin
      if ((sizeNow == 2'h2) && addrOdd) begin
        alignNow = (accessNow == ACC_BOTH) ? PEN_ODD_TWO
                                           : PEN_ODD_ONE;
      end else if ((sizeNow == 2'h2) || ((sizeNow == 2'h1) && addrOdd)) begin
        alignNow = (accessNow == ACC_BOTH) ? PEN_EVEN_TWO
                                           : PEN_EVEN_ONE;
      end
    end
  end

  // wait states count once per data access
  always_comb begin
    case (accessNow)
      ACC_READ, ACC_WRITE: waitNow = {4'h0, waitStates};
      ACC_BOTH:            waitNow = {3'h0, waitStates, 1'b0};
      default:             waitNow = '0;
    endcase
  end

  assign eaNow = (usesModrm && mrm.twoRegEa) ? PEN_EA_PAIR : '0;

  // next values of the result registers
  always_comb begin
    validNext = instrValid;
    knownNext = knownReg;
    formNext  = formReg;
    wideNext  = wideReg;
    memNext   = memReg;
    baseNext  = baseReg;
    penNext   = penReg;
    totalNext = totalReg;
    if (instrValid) begin
      knownNext = (formNow != FORM_NONE);
      formNext  = formNow;
      wideNext  = wideNow;
      memNext   = memNow;
      baseNext  = baseNow;
      penNext   = CNT_W'(alignNow + waitNow + eaNow);
      totalNext = CNT_W'(baseNow + alignNow + waitNow + eaNow);
    end
  end

  // result registers; results hold until the next instruction
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      validReg <= 1'b0;
      knownReg <= 1'b0;
      formReg  <= FORM_NONE;
      wideReg  <= 1'b0;
      memReg   <= 1'b0;
      baseReg  <= '0;
      penReg   <= '0;
      totalReg <= '0;
    end else begin
      validReg <= validNext;
      knownReg <= knownNext;
      formReg  <= formNext;
      wideReg  <= wideNext;
      memReg   <= memNext;
      baseReg  <= baseNext;
      penReg   <= penNext;
      totalReg <= totalNext;
    end
  end

  assign resultValid   = validReg;
  assign formKnown     = knownReg;
  assign formCode      = formReg;
  assign fullWidth     = wideReg;
  assign memOperand    = memReg;
  assign baseClocks    = baseReg;
  assign penaltyClocks = penReg;
  assign totalClocks   = totalReg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_result_latency: assert property (
    instrValid |=> resultValid && (totalClocks == baseClocks + penaltyClocks))
    else $error("result missing or total not base plus penalty");
  chk_copy_to_rm: assert property (
    instrValid && (opByte0[7:1] == OP_COPY_TORM) && !addrSize32
    |=> formCode == FORM_COPY_TO_RM && baseClocks == 8'h02)
    else $error("register to reg/mem copy not 2 clocks");
  chk_copy_to_reg: assert property (
    instrValid && (opByte0[7:1] == OP_COPY_TOREG)
    |=> baseClocks == (memOperand ? 8'h04 : 8'h02))
    else $error("copy into register count wrong");
  chk_seg_load: assert property (
    instrValid && (opByte0 == OP_SEG_LOAD) && protMode &&
    (opByte1[5:3] < SEG_COUNT)
    |=> baseClocks == (memOperand ? 8'h17 : 8'h16))
    else $error("protected segment load count wrong");
  chk_stack_pop: assert property (
    instrValid && (opByte0 == OP_POP_RM) && (opByte1[5:3] == EXT_POP_RM) &&
    !protMode |=> baseClocks == (memOperand ? 8'h07 : 8'h05))
    else $error("real mode stack load count wrong");
  chk_push_imm: assert property (
    instrValid && (opByte0[7:2] == OP_PUSH_IMM) && !opByte0[0]
    |=> baseClocks == ($past(protMode) ? 8'h04 : 8'h02))
    else $error("immediate stack store count wrong");
  chk_odd_dword: assert property (
    instrValid && (opByte0[7:1] == OP_COPY_MEMAC) && opByte0[0] &&
    opSize32 && addrOdd
    |=> penaltyClocks == 8'h04 + {4'h0, $past(waitStates)})
    else $error("odd double word read penalty wrong");
  chk_push_mem_wait: assert property (
    instrValid && (opByte0 == OP_GROUP_FF) && (opByte1 == 8'h37) &&
    !opSize32 && !addrOdd && !addrSize32
    |=> penaltyClocks == {3'h0, $past(waitStates), 1'b0})
    else $error("wait states not counted per access");
  chk_byte_form: assert property (
    instrValid && (opByte0[7:4] == OP_COPY_IMMRG)
    |=> fullWidth == $past(opByte0[3]) && penaltyClocks == 8'h00)
    else $error("immediate copy size bit misread");

  cov_seg_load_prot: cover property (
    instrValid && (opByte0 == OP_SEG_LOAD) && protMode);
  cov_two_reg_ea: cover property (
    instrValid && usesModrm && mrm.twoRegEa);
  cov_both_access: cover property (instrValid && accessNow == ACC_BOTH);
  cov_unknown: cover property (instrValid && formNow == FORM_NONE);

endmodule

// [verif/tb_top.sv]
module tb_top
  import dtd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             clk;
  logic             rst_b;
  logic             instrValid;
  logic [7:0]       opByte0;
  logic [7:0]       opByte1;
  logic [7:0]       opByte2;
  logic [7:0]       sibByte;
  logic             addrSize32;
  logic             opSize32;
  logic             protMode;
  logic             addrOdd;
  logic [3:0]       waitStates;
  logic             resultValid;
  logic             formKnown;
  dtd_form_t        formCode;
  logic             fullWidth;
  logic             memOperand;
  logic [CNT_W-1:0] baseClocks;
  logic [CNT_W-1:0] penaltyClocks;
  logic [CNT_W-1:0] totalClocks;
  int               error_cnt;
  int               samples_checked;
  int               cycleCnt = 0;

  dtd_decode_timing u_dut (
    .clk           (clk),
    .rst_b         (rst_b),
    .instrValid    (instrValid),
    .opByte0       (opByte0),
    .opByte1       (opByte1),
    .opByte2       (opByte2),
    .sibByte       (sibByte),
    .addrSize32    (addrSize32),
    .opSize32      (opSize32),
    .protMode      (protMode),
    .addrOdd       (addrOdd),
    .waitStates    (waitStates),
    .resultValid   (resultValid),
    .formKnown     (formKnown),
    .formCode      (formCode),
    .fullWidth     (fullWidth),
    .memOperand    (memOperand),
    .baseClocks    (baseClocks),
    .penaltyClocks (penaltyClocks),
    .totalClocks   (totalClocks)
  );

  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 3000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %0h expected %0h",
               $time, what, seen, exp);
    end
  endtask

  // operating conditions, always changed at a falling edge
  task automatic mode(input logic a32, input logic o32, input logic pm,
                      input logic odd, input logic [3:0] ws);
    addrSize32 = a32;
    opSize32   = o32;
    protMode   = pm;
    addrOdd    = odd;
    waitStates = ws;
  endtask

  // one instruction per call; valid stays up so calls run back to back
  task automatic run(input logic [7:0] b0, input logic [7:0] b1,
                     input logic [7:0] b2, input logic [7:0] sb,
                     input dtd_form_t f, input logic [7:0] base,
                     input logic [7:0] pen);
    opByte0    = b0;
    opByte1    = b1;
    opByte2    = b2;
    sibByte    = sb;
    instrValid = 1'b1;
    @(negedge clk);
    chk({7'h00, resultValid}, 8'h01, "result pulse");
    chk({7'h00, formKnown}, {7'h00, f != FORM_NONE}, "known");
    chk({4'h0, formCode}, {4'h0, f}, "form");
    chk(baseClocks, base, "base clocks");
    chk(penaltyClocks, pen, "penalty clocks");
    chk(totalClocks, base + pen, "total clocks");
  endtask

  task automatic idle();
    instrValid = 1'b0;
    @(negedge clk);
  endtask

  task automatic copy_forms();
    mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    run(8'h89, 8'hC0, 8'h00, 8'h00, FORM_COPY_TO_RM, 8'h02, 8'h00);
    run(8'h89, 8'h07, 8'h00, 8'h00, FORM_COPY_TO_RM, 8'h02, 8'h00);
    chk({7'h00, memOperand}, 8'h01, "memory operand");
    run(8'h8B, 8'hC0, 8'h00, 8'h00, FORM_COPY_TO_REG, 8'h02, 8'h00);
    chk({7'h00, memOperand}, 8'h00, "register operand");
    run(8'h8B, 8'h07, 8'h00, 8'h00, FORM_COPY_TO_REG, 8'h04, 8'h00);
    run(8'h8B, 8'h00, 8'h00, 8'h00, FORM_COPY_TO_REG, 8'h04, 8'h01);
    mode(1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
    run(8'h88, 8'hC0, 8'h00, 8'h00, FORM_COPY_TO_RM, 8'h02, 8'h00);
    mode(1'b0, 1'b0, 1'b0, 1'b1, 4'h1);
    run(8'h8B, 8'h07, 8'h00, 8'h00, FORM_COPY_TO_REG, 8'h04, 8'h03);
    mode(1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
    run(8'h8B, 8'h04, 8'h00, 8'h18, FORM_COPY_TO_REG, 8'h04, 8'h01);
    run(8'h8B, 8'h04, 8'h00, 8'h20, FORM_COPY_TO_REG, 8'h04, 8'h00);
    idle();
  endtask

  task automatic imm_acc_forms();
    mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    run(8'hB0, 8'h00, 8'h00, 8'h00, FORM_COPY_IMMREG, 8'h02, 8'h00);
    chk({7'h00, fullWidth}, 8'h00, "byte size");
    // no data access, so odd address and waits must not cost anything
    mode(1'b0, 1'b1, 1'b1, 1'b1, 4'h3);
    run(8'hBF, 8'h00, 8'h00, 8'h00, FORM_COPY_IMMREG, 8'h02, 8'h00);
    chk({7'h00, fullWidth}, 8'h01, "full size");
    mode(1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
    run(8'hA1, 8'h00, 8'h00, 8'h00, FORM_COPY_MEMACC, 8'h04, 8'h04);
    run(8'hA3, 8'h00, 8'h00, 8'h00, FORM_COPY_ACCMEM, 8'h02, 8'h04);
    mode(1'b0, 1'b1, 1'b0, 1'b0, 4'h2);
    run(8'hA0, 8'h00, 8'h00, 8'h00, FORM_COPY_MEMACC, 8'h04, 8'h02);
    mode(1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
    run(8'hA3, 8'h00, 8'h00, 8'h00, FORM_COPY_ACCMEM, 8'h02, 8'h02);
    idle();
  endtask

  task automatic seg_forms();
    mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    run(8'h8E, 8'hD8, 8'h00, 8'h00, FORM_SEG_LOAD, 8'h02, 8'h00);
    run(8'h8E, 8'h1F, 8'h00, 8'h00, FORM_SEG_LOAD, 8'h05, 8'h00);
    run(8'h8C, 8'h2F, 8'h00, 8'h00, FORM_SEG_STORE, 8'h02, 8'h00);
    mode(1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
    run(8'h8E, 8'hD8, 8'h00, 8'h00, FORM_SEG_LOAD, 8'h16, 8'h00);
    run(8'h8E, 8'h1F, 8'h00, 8'h00, FORM_SEG_LOAD, 8'h17, 8'h00);
    run(8'h8E, 8'hF0, 8'h00, 8'h00, FORM_NONE, 8'h00, 8'h00);
    run(8'h8C, 8'hE8, 8'h00, 8'h00, FORM_SEG_STORE, 8'h02, 8'h00);
    mode(1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
    run(8'h8E, 8'h1F, 8'h00, 8'h00, FORM_SEG_LOAD, 8'h05, 8'h02);
    idle();
  endtask

  task automatic ext_forms();
    mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    run(8'h0F, 8'hBE, 8'hC0, 8'h00, FORM_SIGN_EXT, 8'h03, 8'h00);
    run(8'h0F, 8'hB6, 8'h07, 8'h00, FORM_ZERO_EXT, 8'h06, 8'h00);
    mode(1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
    run(8'h0F, 8'hB7, 8'hC0, 8'h00, FORM_ZERO_EXT, 8'h03, 8'h00);
    run(8'h0F, 8'hBF, 8'h07, 8'h00, FORM_SIGN_EXT, 8'h06, 8'h00);
    // byte source carries no alignment cost even at an odd address
    mode(1'b0, 1'b1, 1'b0, 1'b1, 4'h0);
    run(8'h0F, 8'hBF, 8'h07, 8'h00, FORM_SIGN_EXT, 8'h06, 8'h02);
    run(8'h0F, 8'hBE, 8'h07, 8'h00, FORM_SIGN_EXT, 8'h06, 8'h00);
    idle();
  endtask

  task automatic stack_forms();
    logic [7:0] b;
    for (int p = 0; p < 2; p++) begin
      mode(1'b0, 1'b0, 1'(p), 1'b0, 4'h0);
      b = (p == 1) ? 8'h04 : 8'h02;
      run(8'hFF, 8'hF0, 8'h00, 8'h00, FORM_PUSH_RM, b + 8'h03, 8'h00);
      run(8'hFF, 8'h37, 8'h00, 8'h00, FORM_PUSH_RM, b + 8'h05, 8'h00);
      run(8'h8F, 8'hC0, 8'h00, 8'h00, FORM_POP_RM, b + 8'h03, 8'h00);
      run(8'h8F, 8'h07, 8'h00, 8'h00, FORM_POP_RM, b + 8'h05, 8'h00);
      for (int s = 0; s < 4; s++) begin
        run({3'h0, 2'(s), 3'h6}, 8'h00, 8'h00, 8'h00,
            FORM_PUSH_SEGN, b, 8'h00);
      end
      for (int s = 0; s < 7; s++) begin
        run(8'h0F, {2'h2, 3'(s), 3'h0}, 8'h00, 8'h00,
            (s < 6) ? FORM_PUSH_SEGW : FORM_NONE,
            (s < 6) ? b : 8'h00, 8'h00);
      end
      run(8'h6A, 8'h00, 8'h00, 8'h00, FORM_PUSH_IMM, b, 8'h00);
      run(8'h68, 8'h00, 8'h00, 8'h00, FORM_PUSH_IMM, b, 8'h00);
    end
    // a memory push both reads and writes, so waits count twice
    mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h1);
    run(8'hFF, 8'h37, 8'h00, 8'h00, FORM_PUSH_RM, 8'h07, 8'h02);
    run(8'hFF, 8'hC0, 8'h00, 8'h00, FORM_NONE, 8'h00, 8'h00);
    mode(1'b0, 1'b0, 1'b1, 1'b1, 4'h0);
    run(8'h8F, 8'h07, 8'h00, 8'h00, FORM_POP_RM, 8'h09, 8'h04);
    run(8'h8F, 8'hC8, 8'h00, 8'h00, FORM_NONE, 8'h00, 8'h00);
    mode(1'b0, 1'b1, 1'b1, 1'b1, 4'h0);
    run(8'h8F, 8'h07, 8'h00, 8'h00, FORM_POP_RM, 8'h09, 8'h08);
    idle();
  endtask

  task automatic pulse_and_reset();
    mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    run(8'h89, 8'hC0, 8'h00, 8'h00, FORM_COPY_TO_RM, 8'h02, 8'h00);
    run(8'h8B, 8'h07, 8'h00, 8'h00, FORM_COPY_TO_REG, 8'h04, 8'h00);
    idle();
    chk({7'h00, resultValid}, 8'h00, "pulse ends");
    chk(totalClocks, 8'h04, "result held");
    rst_b = 1'b0;
    @(negedge clk);
    chk(totalClocks, 8'h00, "reset total");
    chk({4'h0, formCode}, 8'h00, "reset form");
    rst_b = 1'b1;
    @(negedge clk);
  endtask

  // main sequence: every input has a value at time zero
  initial begin
    error_cnt       = 0;
    samples_checked = 0;
    rst_b           = 1'b0;
    instrValid      = 1'b0;
    opByte0         = 8'h00;
    opByte1         = 8'h00;
    opByte2         = 8'h00;
    sibByte         = 8'h00;
    mode(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    copy_forms();
    imm_acc_forms();
    seg_forms();
    ext_forms();
    stack_forms();
    pulse_and_reset();
    finish_test();
  end
endmodule
